// >>> logic/core_interrupt_priority_controller.sv
// interrupt priority controller: pending flags, arbitration, two-word vector fetch
// assumes the core sequencer pulses instr_done after each instruction and
// reports jsr and routine end for the inserted words
//
// Contract
// - unmasked internal source served, request auto-cleared
// - each maskable internal source separately enabled
// - nmi edge-detected, level 3, never masked
// - edge request pends on fall, clears on service
// - disabled external request ignored, latch held reset
// - disabling level request cancels unless already fetched
// - undefined opcode raises level-3 exception immediately
// - taken trap raises level-3 exception immediately
// - status mask blocks levels below it, never 3
// - level field 00 off, else level field-1
// - trigger bit 0 level, 1 falling edge
// - priority registers read-write, cleared by resets
// - highest pending level served first
// - level-3 fixed order stack to peripheral nmi
// - maskable order a,b,c,d, dma0-5, peripherals
// - prior multi-cycle fetch aborted, refetched after return
// - prior one-cycle instruction completes before routine
// - vector fetch reads start address then next
// - fast routine not interruptible, status unsaved
// - jsr in vector forms long routine, masks raised
// - long routine interruptible only by higher levels; a level-3 routine still admits level 3, as mask 3 never blocks it
// - arbitrate after each instruction against status mask
// - pending flag held until second word fetched
// - each source has two-word slot from base
`timescale 1ns/1ps
module core_interrupt_priority_controller
  import icu_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             reset_instr,
  input  wire logic             core_prio_wr,
  input  wire logic             periph_prio_wr,
  input  wire logic [W-1:0]     prio_wdata,
  output logic      [W-1:0]     core_interrupt_priority,
  output logic      [W-1:0]     peripheral_interrupt_priority,
  input  wire logic             nmi_n,
  input  wire logic [N_EXT-1:0] ext_request_n,
  input  wire logic             stack_error,
  input  wire logic             bad_opcode_exception,
  input  wire logic             debug_request,
  input  wire logic             trap_taken,
  input  wire logic             nm_periph_request,
  input  wire logic [N_DMA-1:0] dma_request,
  input  wire logic [N_PER-1:0] periph_request,
  input  wire logic             mask_bit_high,
  input  wire logic             mask_bit_low,
  input  wire logic [W-1:0]     vector_base,
  input  wire logic             instr_done,
  input  wire logic             multicycle_fetched,
  input  wire logic             vector_jsr,
  input  wire logic             fast_done,
  output logic                  int_fetch,
  output logic      [W-1:0]     vec_addr,
  output logic                  abort_prev,
  output logic      [N_EXT-1:0] ext_ack,
  output logic                  long_entry,
  output logic      [1:0]       new_mask,
  output logic                  fast_active
);

  ////////////////////////////////////////////////////////////////////////////
  // priority registers

  logic [W-1:0] core_prio_q;
  logic [W-1:0] periph_prio_q;

  always_ff @(posedge core_clk)
    if (reset)
      core_prio_q <= PRIO_RST;
    else if (clk_en)
    begin
      if (reset_instr)
        core_prio_q <= PRIO_RST;
      else if (core_prio_wr)
        core_prio_q <= prio_wdata;
    end

  always_ff @(posedge core_clk)
    if (reset)
      periph_prio_q <= PRIO_RST;
    else if (clk_en)
    begin
      if (reset_instr)
        periph_prio_q <= PRIO_RST;
      else if (periph_prio_wr)
        periph_prio_q <= prio_wdata;
    end

  assign core_interrupt_priority       = core_prio_q;
  assign peripheral_interrupt_priority = periph_prio_q;

  ////////////////////////////////////////////////////////////////////////////
  // per-source level fields, enables and pending flags

  arb_if arb ();

  seq_state_t       st_q;
  logic [IDX_W-1:0] cur_idx_q;
  logic [1:0]       cur_ipl_q;
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] set_vec;
  logic [N_SRC-1:0] clear_vec;
  logic [N_SRC-1:0] enabled;
  logic [1:0]       fld [N_SRC];
  logic [N_EXT:0]   ext_trig;

  // internal sources arrive as one-cycle pulses from logic on this clock
  assign set_vec = {periph_request, dma_request, {N_EXT{1'b0}}, nm_periph_request,
                    1'b0, trap_taken, debug_request, bad_opcode_exception,
                    stack_error};

  genvar g;
  generate
    for (g = 0; g < N_SRC; g++)
    begin : g_src
      // pending flag drops only when the second vector word is fetched
      assign clear_vec[g] = clk_en && st_q == ST_FETCH2 && cur_idx_q == IDX_W'(g);

      if (g < SRC_EXT)
      begin : g_l3
        assign fld[g]     = FLD_OFF;
        assign enabled[g] = 1'b1;
        assign arb.priority_level[g] = IPL_TOP;
      end
      else
      begin : g_mask
        if (g < SRC_DMA)
          assign fld[g] = core_prio_q[EXT_FLD_POS + EXT_FLD_W*(g-SRC_EXT) +: LVL_W];
        else if (g < SRC_PER)
          assign fld[g] = core_prio_q[DMA_FLD_POS + LVL_W*(g-SRC_DMA) +: LVL_W];
        else
          assign fld[g] = periph_prio_q[PER_FLD_POS + LVL_W*(g-SRC_PER) +: LVL_W];
        assign enabled[g] = fld[g] != FLD_OFF;
        assign arb.priority_level[g] = fld[g] - 2'h1;
      end

      if (g == SRC_NMI || (g >= SRC_EXT && g < SRC_DMA))
      begin : g_pin
        localparam int K = (g == SRC_NMI) ? N_EXT : g - SRC_EXT;
        logic pin_sel;
        // split so the nmi branch never indexes past the request pins
        if (g == SRC_NMI)
        begin : g_nmi
          assign ext_trig[K] = 1'b1;
          assign pin_sel     = nmi_n;
        end
        else
        begin : g_irq
          assign ext_trig[K] = core_prio_q[EXT_FLD_POS + EXT_FLD_W*K + EXT_TRIG];
          assign pin_sel     = ext_request_n[K];
        end
        ext_request_latch u_latch (
          .core_clk  (core_clk),
          .reset     (reset),
          .clk_en    (clk_en),
          .pin_n     (pin_sel),
          .enable    (enabled[g]),
          .edge_mode (ext_trig[K]),
          .clear     (clear_vec[g]),
          .pending   (pend[g])
        );
      end
      else
      begin : g_int
        logic pend_q;
        // a new request in the clear cycle is kept: set beats clear
        always_ff @(posedge core_clk)
          if (reset)
            pend_q <= 1'b0;
          else if (clk_en)
          begin
            if (set_vec[g])
              pend_q <= 1'b1;
            else if (clear_vec[g])
              pend_q <= 1'b0;
          end
        assign pend[g] = pend_q;
      end
    end
  endgenerate

  assign arb.req  = pend & enabled;
  assign arb.mask = {mask_bit_high, mask_bit_low};

  priority_arbiter u_arb (
    .bus (arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // vector fetch sequence

  logic start;

  // arbitration only from idle: a fast routine cannot be interrupted
  assign start = st_q == ST_IDLE && instr_done && arb.grant_valid;

  always_ff @(posedge core_clk)
    if (reset)
      st_q <= ST_IDLE;
    else if (clk_en)
    begin
      unique case (st_q)
        ST_IDLE:   if (start) st_q <= ST_FETCH1;
        ST_FETCH1: st_q <= ST_FETCH2;
        ST_FETCH2: st_q <= ST_FAST;
        ST_FAST:   if (vector_jsr || fast_done) st_q <= ST_IDLE;
      endcase
    end

  // the chosen source is frozen at start, so a later disable cannot cancel it
  always_ff @(posedge core_clk)
    if (reset)
    begin
      cur_idx_q <= '0;
      cur_ipl_q <= 2'h0;
    end
    else if (clk_en && start)
    begin
      cur_idx_q <= arb.grant_idx;
      cur_ipl_q <= arb.grant_ipl;
    end

  always_ff @(posedge core_clk)
    if (reset)
      vec_addr <= '0;
    else if (clk_en)
    begin
      if (start)
        vec_addr <= vector_base + W'(VEC_OFF[arb.grant_idx]);
      else if (st_q == ST_FETCH1)
        vec_addr <= vec_addr + W'(1);
    end

  // one-cycle instructions run on; longer ones are dropped and refetched
  always_ff @(posedge core_clk)
    if (reset)
      abort_prev <= 1'b0;
    else if (clk_en)
      abort_prev <= start && multicycle_fetched;

  always_ff @(posedge core_clk)
    if (reset)
      ext_ack <= '0;
    else if (clk_en)
      for (int k = 0; k < N_EXT; k++)
        ext_ack[k] <= st_q == ST_FETCH1 && cur_idx_q == IDX_W'(SRC_EXT + k);

  // long routine: core stacks pc and status, clears loop, scaling and
  // sixteen-bit mode, and loads the raised mask
  always_ff @(posedge core_clk)
    if (reset)
    begin
      long_entry <= 1'b0;
      new_mask   <= 2'h0;
    end
    else if (clk_en)
    begin
      long_entry <= st_q == ST_FAST && vector_jsr;
      if (st_q == ST_FAST && vector_jsr)
        new_mask <= (cur_ipl_q == IPL_TOP) ? IPL_TOP : cur_ipl_q + 2'h1;
    end

  assign int_fetch   = st_q == ST_FETCH1 || st_q == ST_FETCH2;
  assign fast_active = st_q == ST_FAST;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence fetch_pair_s;
    st_q == ST_FETCH1 && clk_en ##1 st_q == ST_FETCH2;
  endsequence

  sequence start_s;
    start && clk_en;
  endsequence

  fetch_order_a: assert property (start_s |=> fetch_pair_s)
    else $error("vector fetch did not follow start");

  word_pair_a: assert property (fetch_pair_s |-> vec_addr == $past(vec_addr) + W'(1))
    else $error("second vector word not at next address");

  slot_addr_a: assert property (start_s |=> vec_addr ==
                                vector_base + W'(VEC_OFF[cur_idx_q]))
    else $error("vector address not the source slot");

  mask_gate_a: assert property (arb.grant_valid |->
                 arb.grant_ipl == IPL_TOP || arb.grant_ipl >= arb.mask)
    else $error("granted a masked level");

  nmi_unmasked_a: assert property (pend[SRC_NMI] && arb.req[SRC_NMI]
                    && arb.req[3:0] == 4'h0 |-> arb.grant_valid
                    && arb.grant_idx == IDX_W'(SRC_NMI))
    else $error("nmi not granted");

  no_nest_fast_a: assert property (st_q == ST_FAST |-> !start)
    else $error("fast routine was interrupted");

  disabled_ext_a: assert property (clk_en && !enabled[SRC_EXT] |=> !pend[SRC_EXT])
    else $error("disabled request still pending");

  prio_clear_a: assert property (clk_en && reset_instr |=>
                  core_prio_q == PRIO_RST && periph_prio_q == PRIO_RST)
    else $error("priority registers not cleared");

  long_mask_a: assert property (clk_en && st_q == ST_FAST && vector_jsr |=>
                 long_entry && st_q == ST_IDLE && new_mask >= cur_ipl_q)
    else $error("long routine entry wrong");

  ack_pulse_a: assert property (start_s ##1 clk_en && cur_idx_q == IDX_W'(SRC_EXT)
                 |=> ext_ack[0])
    else $error("external acknowledge missing");

  // pins keep their own latch rules, so only internal flags are followed here
  logic cur_internal;
  assign cur_internal = cur_idx_q != IDX_W'(SRC_NMI)
                        && (cur_idx_q < IDX_W'(SRC_EXT) || cur_idx_q >= IDX_W'(SRC_DMA));

  sequence fetch_second_s;
    clk_en && st_q == ST_FETCH2 && cur_internal && !set_vec[cur_idx_q];
  endsequence

  pend_held_a: assert property (clk_en && st_q == ST_FETCH1 && cur_internal
                 |-> pend[cur_idx_q])
    else $error("pending flag dropped before second word");

  pend_clear_a: assert property (fetch_second_s |=> !pend[cur_idx_q])
    else $error("pending flag kept after second word");

  abort_multi_a: assert property (start_s && multicycle_fetched |=> abort_prev)
    else $error("multi-cycle instruction not aborted");

  keep_single_a: assert property (start_s && !multicycle_fetched |=> !abort_prev)
    else $error("one-cycle instruction aborted");

  stack_first_a: assert property (arb.req[SRC_STACK] |->
                   arb.grant_valid && arb.grant_idx == IDX_W'(SRC_STACK))
    else $error("stack error not granted first");

  ext_first_a: assert property (arb.req[SRC_EXT] && arb.priority_level[SRC_EXT] == 2'h2
                 && arb.mask != IPL_TOP && arb.req[SRC_NMPER:SRC_STACK] == 6'h00
                 |-> arb.grant_valid && arb.grant_idx == IDX_W'(SRC_EXT))
    else $error("request a not first among maskable");

  fast_hold_a: assert property (clk_en && st_q == ST_FAST && !vector_jsr && !fast_done
                 |=> st_q == ST_FAST)
    else $error("fast routine left early");

endmodule // core_interrupt_priority_controller

// >>> inc/icu_pkg.sv
// constants, source numbering and state codes of the interrupt priority controller
// assumes a single core clock; shared by every design file of the block
package icu_pkg;

  localparam int W        = 24;
  localparam int N_EXT    = 4;
  localparam int N_DMA    = 6;
  localparam int N_PER    = 4;
  localparam int N_SRC    = 20;
  localparam int IDX_W    = 5;

  // source numbering follows the fixed order inside a level, highest first
  localparam int SRC_STACK = 0;
  localparam int SRC_BADOP = 1;
  localparam int SRC_DEBUG = 2;
  localparam int SRC_TRAP  = 3;
  localparam int SRC_NMI   = 4;
  localparam int SRC_NMPER = 5;
  localparam int SRC_EXT   = 6;
  localparam int SRC_DMA   = 10;
  localparam int SRC_PER   = 16;

  // field positions inside the two priority registers
  localparam int EXT_FLD_POS = 0;
  localparam int EXT_FLD_W   = 3;
  localparam int EXT_TRIG    = 2;
  localparam int DMA_FLD_POS = 12;
  localparam int PER_FLD_POS = 0;
  localparam int LVL_W       = 2;

  localparam logic [W-1:0] PRIO_RST = 24'h000000;
  localparam logic [1:0]   IPL_TOP  = 2'h3;
  localparam logic [1:0]   FLD_OFF  = 2'h0;

  // two-word slot of each source, relative to the vector base
  localparam logic [7:0] VEC_OFF [N_SRC] = '{
    8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c,
    8'h10, 8'h12, 8'h14, 8'h16,
    8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20, 8'h22,
    8'h24, 8'h26, 8'h28, 8'h2a};

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FETCH1 = 4'b0010,
    ST_FETCH2 = 4'b0100,
    ST_FAST   = 4'b1000
  } seq_state_t;

endpackage

// >>> inc/arb_if.sv
// request and grant signals between the controller and its arbiter
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface arb_if;
  import icu_pkg::*;
  logic [N_SRC-1:0]  req;
  logic [1:0]        priority_level [N_SRC];
  logic [1:0]        mask;
  logic              grant_valid;
  logic [IDX_W-1:0]  grant_idx;
  logic [1:0]        grant_ipl;

  modport ctrl (output req, priority_level, mask, input grant_valid, grant_idx, grant_ipl);
  modport arb  (input req, priority_level, mask, output grant_valid, grant_idx, grant_ipl);
endinterface

// >>> logic/ext_request_latch.sv
// one external request line: synchroniser, falling-edge latch and level path
// assumes pin_n is asynchronous to core_clk
`timescale 1ns/1ps
module ext_request_latch
  import icu_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic pin_n,
  input  wire logic enable,
  input  wire logic edge_mode,
  input  wire logic clear,
  output logic      pending
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic latch_q;
  logic fall;

  always_ff @(posedge core_clk)
    if (reset)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end
    else if (clk_en)
    begin
      sync1_q <= pin_n;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end

  assign fall = prev_q & ~sync2_q;

  // set wins over clear so an edge in the service cycle is kept
  always_ff @(posedge core_clk)
    if (reset)
      latch_q <= 1'b0;
    else if (clk_en)
    begin
      if (!enable)
        latch_q <= 1'b0;
      else if (edge_mode && fall)
        latch_q <= 1'b1;
      else if (clear)
        latch_q <= 1'b0;
    end

  // level mode is never cleared here: the source withdraws the line itself
  assign pending = enable & (edge_mode ? latch_q : ~sync2_q);

  latch_off_a: assert property (@(posedge core_clk) disable iff (reset)
                 clk_en && !enable |=> !latch_q)
    else $error("detection latch not held in reset");

  edge_catch_a: assert property (@(posedge core_clk) disable iff (reset)
                  clk_en && enable && edge_mode && fall |=> latch_q)
    else $error("falling edge not latched");
endmodule // ext_request_latch

// >>> logic/priority_arbiter.sv
// picks the highest unmasked level, then the lowest source number
// assumes requests are already filtered by their enables
`timescale 1ns/1ps
module priority_arbiter
  import icu_pkg::*;
(
  arb_if.arb bus
);
  always_comb
  begin
    bus.grant_valid = 1'b0;
    bus.grant_idx   = '0;
    bus.grant_ipl   = 2'h0;
    for (int i = 0; i < N_SRC; i++)
      if (bus.req[i] && (bus.priority_level[i] == IPL_TOP || bus.priority_level[i] >= bus.mask)
          && (!bus.grant_valid || bus.priority_level[i] > bus.grant_ipl))
      begin
        bus.grant_valid = 1'b1;
        bus.grant_idx   = IDX_W'(i);
        bus.grant_ipl   = bus.priority_level[i];
      end
  end
endmodule // priority_arbiter

// >>> tb/ext_source_model.sv
// far-side model: external request pins a..d and the non-maskable pin
// assumes go strobes come from the bench on the falling edge, one cycle each
`timescale 1ns/1ps
module ext_source_model
(
  input  wire logic       core_clk,
  input  wire logic [3:0] level_go,
  input  wire logic [3:0] edge_go,
  input  wire logic       nmi_go,
  input  wire logic [3:0] ext_ack,
  output logic      [3:0] ext_request_n,
  output logic            nmi_n
);
  logic [3:0] held_q = 4'h0;
  int         low_cnt [5] = '{default: 0};
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ext_request_n = 4'hf;
    nmi_n         = 1'b1;
  end
  // pins idle high on their pull-ups; an edge request is a short low pulse
  always @(negedge core_clk)
  begin
    for (int k = 0; k < 5; k++)
    begin
      if (k < 4 && ext_ack[k])
        held_q[k] = 1'b0;  // level source withdraws on acknowledge
      if (k < 4 && level_go[k])
        held_q[k] = 1'b1;
      if ((k < 4) ? edge_go[k] : nmi_go)
        low_cnt[k] = 4;
      else if (low_cnt[k] > 0)
        low_cnt[k] = low_cnt[k] - 1;
      if (k < 4)
        ext_request_n[k] = !(held_q[k] || low_cnt[k] > 0);
      else
        nmi_n = !(low_cnt[k] > 0);
    end
  end
endmodule // ext_source_model

// >>> tb/tb_top.sv
// self-checking bench of the interrupt priority controller against a queue-free model
// assumes ext_source_model drives the pins; core sequencer is played by the bench
`timescale 1ns/1ps
module tb_top;
  import icu_pkg::*;
  logic             core_clk = 1'b0;
  logic             reset = 1'b1;
  logic             clk_en = 1'b1;
  logic             reset_instr = 1'b0;
  logic             core_prio_wr = 1'b0;
  logic             periph_prio_wr = 1'b0;
  logic [W-1:0]     prio_wdata = '0;
  logic [W-1:0]     cip_o, pip_o, vec_addr;
  logic             nmi_n, nmi_go = 1'b0;
  logic [N_EXT-1:0] ext_n, ext_ack, level_go = '0, edge_go = '0;
  logic [5:0]       top_evt = '0;
  logic [N_DMA-1:0] dma_request = '0;
  logic [N_PER-1:0] periph_request = '0;
  logic [1:0]       msk = '0, new_mask;
  logic [W-1:0]     vector_base = '0, cip = '0, pip = '0, d;
  logic             instr_done = 1'b0, multicycle_fetched = 1'b0;
  logic             vector_jsr = 1'b0, fast_done = 1'b0;
  logic             int_fetch, abort_prev, long_entry, fast_active;
  int               err_count = 0;
  int               num_checks = 0;
  int               last_w;
  bit               pend [N_SRC];
  ////////////////////////////////////////////////////////////////////////////
  always #25 core_clk = ~core_clk;
  core_interrupt_priority_controller i_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reset_instr(reset_instr),
    .core_prio_wr(core_prio_wr), .periph_prio_wr(periph_prio_wr),
    .prio_wdata(prio_wdata), .core_interrupt_priority(cip_o),
    .peripheral_interrupt_priority(pip_o), .nmi_n(nmi_n), .ext_request_n(ext_n),
    .stack_error(top_evt[0]), .bad_opcode_exception(top_evt[1]),
    .debug_request(top_evt[2]), .trap_taken(top_evt[3]),
    .nm_periph_request(top_evt[5]), .dma_request(dma_request),
    .periph_request(periph_request), .mask_bit_high(msk[1]), .mask_bit_low(msk[0]),
    .vector_base(vector_base), .instr_done(instr_done),
    .multicycle_fetched(multicycle_fetched), .vector_jsr(vector_jsr),
    .fast_done(fast_done), .int_fetch(int_fetch), .vec_addr(vec_addr),
    .abort_prev(abort_prev), .ext_ack(ext_ack), .long_entry(long_entry),
    .new_mask(new_mask), .fast_active(fast_active));
  ext_source_model i_src (
    .core_clk(core_clk), .level_go(level_go), .edge_go(edge_go), .nmi_go(nmi_go),
    .ext_ack(ext_ack), .ext_request_n(ext_n), .nmi_n(nmi_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input int exp, input logic [W-1:0] got);
    num_checks++;
    if (got !== W'(exp))
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, W'(exp), got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input bit per, input logic [W-1:0] v);
    @(negedge core_clk);
    core_prio_wr   = !per;
    periph_prio_wr = per;
    prio_wdata     = v;
    @(negedge core_clk);
    core_prio_wr   = 1'b0;
    periph_prio_wr = 1'b0;
    if (per)
      pip = v;
    else
      cip = v;
  endtask
  // model level of a source: -1 when its field is off
  function automatic int lvl(input int s);
    int f;
    if (s < SRC_EXT)
      return 3;
    if (s < SRC_DMA)
      f = cip[3*(s-SRC_EXT) +: 2];
    else if (s < SRC_PER)
      f = cip[DMA_FLD_POS+2*(s-SRC_DMA) +: 2];
    else
      f = pip[2*(s-SRC_PER) +: 2];
    return f - 1;
  endfunction
  // highest unmasked level, then lowest number inside that level
  function automatic int pick(output int priority_level);
    int best;
    best = -1;
    priority_level  = -1;
    for (int s = 0; s < N_SRC; s++)
      if (pend[s] && lvl(s) >= 0 && (lvl(s) == 3 || lvl(s) >= msk) && lvl(s) > priority_level)
      begin
        best = s;
        priority_level  = lvl(s);
      end
    return best;
  endfunction
  task automatic serve();
    int       w, l;
    logic     jsr, mc;
    w        = pick(l);
    last_w   = w;
    jsr      = 1'($urandom);
    mc       = 1'($urandom);
    @(negedge core_clk);
    instr_done         = 1'b1;
    multicycle_fetched = mc;
    @(negedge core_clk);
    instr_done         = 1'b0;
    multicycle_fetched = 1'b0;
    if (w < 0)
    begin
      repeat (3) @(negedge core_clk) check("int_fetch none", 0, int_fetch);
      return;
    end
    check("int_fetch", 1, int_fetch);
    check("vec_addr first", int'(vector_base) + VEC_OFF[w], vec_addr);
    check("abort_prev", mc, abort_prev);
    @(negedge core_clk);
    check("vec_addr second", int'(vector_base) + VEC_OFF[w] + 1, vec_addr);
    check("ext_ack", (w >= SRC_EXT && w < SRC_DMA) ? 1 << (w - SRC_EXT) : 0, ext_ack);
    @(negedge core_clk);
    check("fast_active", 1, fast_active);
    if (mc)
    begin
      // an instruction end inside a fast routine must not start arbitration
      instr_done = 1'b1;
      @(negedge core_clk);
      check("fast_active held", 1, fast_active);
    end
    vector_jsr = jsr;
    fast_done  = !jsr;
    instr_done = 1'b1;
    @(negedge core_clk);
    vector_jsr = 1'b0;
    fast_done  = 1'b0;
    instr_done = 1'b0;
    check("int_fetch in routine", 0, int_fetch);
    check("long_entry", jsr, long_entry);
    if (jsr)
      check("new_mask", (l == 3) ? 3 : l + 1, new_mask);
    pend[w] = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic drain();
    repeat (N_SRC + 1)
    begin
      serve();
      if (last_w < 0)
        break;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(60000 * 50);
    err_count++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'h8afd));
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    check("core reg reset", 0, cip_o);
    check("periph reg reset", 0, pip_o);
    wr(0, 24'ha5c3e1);
    check("core reg", 24'ha5c3e1, cip_o);
    wr(1, 24'h5a3c1e);
    check("periph reg", 24'h5a3c1e, pip_o);
    // a frozen block must swallow the reset instruction
    clk_en      = 1'b0;
    reset_instr = 1'b1;
    @(negedge core_clk);
    clk_en = 1'b1;
    check("core reg frozen", 24'ha5c3e1, cip_o);
    reset_instr = 1'b1;
    @(negedge core_clk);
    reset_instr = 1'b0;
    @(negedge core_clk);
    check("core reg cleared", 0, cip_o);
    check("periph reg cleared", 0, pip_o);
    cip = '0;
    pip = '0;
    // random levels, mask and simultaneous internal events
    repeat (6)
    begin
      vector_base = {16'($urandom), 8'h00};
      d = '0;
      for (int k = 0; k < N_DMA; k++)
        d[DMA_FLD_POS+2*k +: 2] = 2'($urandom_range(3, 1));
      wr(0, d);
      d = '0;
      for (int k = 0; k < N_PER; k++)
        d[2*k +: 2] = 2'($urandom_range(3, 1));
      wr(1, d);
      @(negedge core_clk);
      msk            = 2'($urandom);
      dma_request    = N_DMA'($urandom);
      periph_request = N_PER'($urandom);
      top_evt        = 6'($urandom) & 6'h2f;
      for (int s = 0; s < N_SRC; s++)
        pend[s] = pend[s] | (s < SRC_EXT ? top_evt[s] : 1'b0)
                | (s >= SRC_DMA && s < SRC_PER ? dma_request[s-SRC_DMA] : 1'b0)
                | (s >= SRC_PER ? periph_request[s-SRC_PER] : 1'b0);
      @(negedge core_clk);
      dma_request    = '0;
      periph_request = '0;
      top_evt        = '0;
      drain();
      msk = 2'h0;
      drain();
    end
    // pins: a edge at level 2, b level at 1, c edge but off, nmi under full mask
    wr(0, 24'h000317);
    msk = 2'h3;
    edge_go <= 4'b0101;
    level_go <= 4'b0010;
    nmi_go <= 1'b1;
    @(negedge core_clk);
    edge_go <= '0;
    level_go <= '0;
    nmi_go <= 1'b0;
    repeat (6) @(negedge core_clk);
    pend[SRC_NMI]   = 1'b1;
    pend[SRC_EXT]   = 1'b1;
    pend[SRC_EXT+1] = 1'b1;
    drain();
    msk = 2'h0;
    drain();
    level_go <= 4'b1000;
    @(negedge core_clk);
    level_go <= '0;
    repeat (6) @(negedge core_clk);
    wr(0, 24'h000117);
    serve();
    test_done();
  end
endmodule // tb_top
